// ### rtl/nabi_host.sv
// Host controller driving the asynchronous flash strobe bus, ordered over APB
// Function
// - Commands and addresses go only on low lanes; upper lanes carry data only.
// - Host drives upper lanes to zero during every command cycle.
// - Host drives unused address bits low; cycle count depends on command.
// - Data is eight bits narrow, sixteen bits wide parts.
// - Host samples on read strobe rise when read cycle time is 30ns+.
// - After addressed status query, host issues read mode before array reads; the host only sets readModeNeeded in status and issues nothing itself.
// - Host changes write protect only when idle, then waits settle time.
// - After power ramp host waits for ready high before reset command.
// - Without ready monitoring, host waits 100us before first command.
// - Reset is first command after power-on; target then busy 1ms.
// - Address is two column then three row cycles; block bit six picks plane.
`timescale 1ns/1ns
`default_nettype none
module nabi_host #(
	parameter int POWER_WAIT = nabi_pkg::POWER_WAIT_CYC,
	parameter int RESET_WAIT = nabi_pkg::RESET_BUSY_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] ioIn,
	output logic [15:0] ioOut,
	output logic ioOe,
	input wire logic readyBusy_n,
	output logic chipEnable_n,
	output logic cmdLatch,
	output logic addrLatch,
	output logic writeStrobe_n,
	output logic readStrobe_n,
	output logic writeProtect_n
);
	typedef enum logic [2:0] {
		ST_POWER = 3'b000,
		ST_RESET = 3'b001,
		ST_SETTLE = 3'b011,
		ST_IDLE = 3'b010,
		ST_LOW = 3'b110,
		ST_HIGH = 3'b111,
		ST_WAIT = 3'b101
	} nabi_state_e;
	typedef struct packed {
		nabi_state_e state;
		nabi_pkg::nabi_pins_s pins;
		logic [31:0] ctrl;
		logic [15:0] rdata;
		logic [27:0] count;
		logic busy;
		logic initDone;
		logic readModeNeeded;
		logic protectRefused;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} nabi_st_s;
	nabi_st_s st_r;
	nabi_st_s st_nxt;
	logic [16:0] pinsSync;
	logic rbReady;
	logic [15:0] ioSync;
	nabi_pkg::nabi_kind_e kind;
	logic [15:0] word;
	logic engineBusy;

	// Pin inputs pass two flops before use
	nabi_sync #(.W(17)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({readyBusy_n, ioIn}),
		.q(pinsSync)
	);
	assign rbReady = pinsSync[16];
	assign ioSync = pinsSync[15:0];
	assign kind = nabi_pkg::nabi_kind_e'(st_r.ctrl[nabi_pkg::CTRL_KIND_LSB +: 3]);
	assign word = st_r.ctrl[15:0];
	// Engine in use: before init, outside idle, or with an order still pending
	assign engineBusy = !st_r.initDone || st_r.state != ST_IDLE
		|| st_r.ctrl[nabi_pkg::CTRL_GO_BIT];

	// Strobe pattern for one cycle kind
	function automatic nabi_pkg::nabi_pins_s drive(input nabi_pkg::nabi_pins_s p,
			input nabi_pkg::nabi_kind_e k, input logic [15:0] w, input logic wide,
			input logic active);
		nabi_pkg::nabi_pins_s o;
		o = p;
		o.chipEnable_n = 1'b0;
		o.cmdLatch = (k == nabi_pkg::KIND_CMD);
		o.addrLatch = (k == nabi_pkg::KIND_ADDR);
		o.ioOe = (k != nabi_pkg::KIND_READ);
		// Command and address on low lanes, upper lanes zero
		if (k == nabi_pkg::KIND_CMD || k == nabi_pkg::KIND_ADDR || !wide) begin
			o.ioOut = {8'h00, w[7:0]};
		end else begin
			o.ioOut = w; // Full lane set on wide parts
		end
		o.writeStrobe_n = !(active && k != nabi_pkg::KIND_READ);
		o.readStrobe_n = !(active && k == nabi_pkg::KIND_READ);
		return o;
	endfunction

	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		st_nxt.busy = !st_r.initDone || st_r.state != ST_IDLE;
		st_nxt.count = (st_r.count != 28'h0) ? st_r.count - 28'h1 : 28'h0;
		// APB slave: answer one cycle after the access phase begins
		if (psel && penable && !st_r.pready) begin
			st_nxt.pready = 1'b1;
			st_nxt.prdata = 32'h0000_0000;
			case (paddr)
				nabi_pkg::OFS_CTRL: begin
					st_nxt.prdata = st_r.ctrl;
					if (pwrite) begin
						// A write while the engine runs would move the word under the strobe
						if (engineBusy) begin
							st_nxt.pslverr = 1'b1;
						end else begin
							st_nxt.ctrl = pwdata;
						end
					end
				end
				nabi_pkg::OFS_RDATA: st_nxt.prdata = {16'h0000, st_r.rdata};
				nabi_pkg::OFS_STAT: st_nxt.prdata = {27'h0, st_r.protectRefused,
					st_r.readModeNeeded, rbReady, st_r.initDone, st_r.busy};
				default: st_nxt.pslverr = 1'b1;
			endcase
		end
		case (st_r.state)
			// Power-on wait: ready high and minimum time elapsed
			ST_POWER: begin
				st_nxt.pins.chipEnable_n = 1'b1;
				st_nxt.pins.writeProtect_n = 1'b0;
				if (st_r.count == 28'h0 && rbReady) begin
					st_nxt.pins = drive(st_r.pins, nabi_pkg::KIND_CMD,
						{8'h00, nabi_pkg::CMD_RESET}, 1'b0, 1'b1); // Reset first
					st_nxt.count = 28'(nabi_pkg::STROBE_HALF_CYC);
					st_nxt.state = ST_RESET;
				end
			end
			// Finish reset strobe, then wait out reset busy time
			ST_RESET: begin
				if (st_r.count == 28'h0 && !st_r.pins.writeStrobe_n == 1'b1) begin
					st_nxt.pins.writeStrobe_n = 1'b1;
					st_nxt.count = 28'(RESET_WAIT);
				end else if (st_r.count == 28'h0 && rbReady) begin
					st_nxt.pins.cmdLatch = 1'b0;
					st_nxt.pins.ioOe = 1'b0;
					st_nxt.initDone = 1'b1;
					st_nxt.state = ST_IDLE;
				end
			end
			ST_SETTLE: begin
				if (st_r.count == 28'h0) begin
					st_nxt.state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				st_nxt.pins.chipEnable_n = st_r.ctrl[nabi_pkg::CTRL_CE_BIT];
				st_nxt.pins.cmdLatch = 1'b0;
				st_nxt.pins.addrLatch = 1'b0;
				st_nxt.pins.ioOe = 1'b0;
				if (st_r.ctrl[nabi_pkg::CTRL_GO_BIT]) begin
					st_nxt.ctrl[nabi_pkg::CTRL_GO_BIT] = 1'b0;
					if (kind == nabi_pkg::KIND_PROT) begin
						// Protect change only while target ready
						if (rbReady) begin
							st_nxt.pins.writeProtect_n = st_r.ctrl[nabi_pkg::CTRL_PROT_BIT];
							st_nxt.count = 28'(nabi_pkg::PROTECT_SETTLE_CYC);
							st_nxt.state = ST_SETTLE;
							st_nxt.protectRefused = 1'b0;
						end else begin
							st_nxt.protectRefused = 1'b1;
						end
					end else begin
						if (kind == nabi_pkg::KIND_CMD) begin
							// Track read mode after addressed status query
							if (word[7:0] == nabi_pkg::CMD_ADDR_STATUS) begin
								st_nxt.readModeNeeded = 1'b1;
							end else if (word[7:0] == nabi_pkg::CMD_READ_MODE) begin
								st_nxt.readModeNeeded = 1'b0;
							end
						end
						st_nxt.pins = drive(st_r.pins, kind, word,
							st_r.ctrl[nabi_pkg::CTRL_WIDE_BIT], 1'b0);
						st_nxt.count = 28'(nabi_pkg::STROBE_HALF_CYC);
						st_nxt.state = ST_LOW;
					end
				end
			end
			// Setup half, then strobe low
			ST_LOW: begin
				if (st_r.count == 28'h0) begin
					st_nxt.pins = drive(st_r.pins, kind, word,
						st_r.ctrl[nabi_pkg::CTRL_WIDE_BIT], 1'b1);
					st_nxt.count = 28'(nabi_pkg::STROBE_HALF_CYC);
					st_nxt.state = ST_HIGH;
				end
			end
			// Strobe high; read data taken at the rising read strobe
			ST_HIGH: begin
				if (st_r.count == 28'h0) begin
					st_nxt.pins.writeStrobe_n = 1'b1;
					st_nxt.pins.readStrobe_n = 1'b1;
					if (kind == nabi_pkg::KIND_READ) begin
						st_nxt.rdata = st_r.ctrl[nabi_pkg::CTRL_WIDE_BIT] ? ioSync
							: {8'h00, ioSync[7:0]};
					end
					st_nxt.count = 28'(nabi_pkg::STROBE_HALF_CYC);
					st_nxt.state = ST_WAIT;
				end
			end
			// Hold time after the edge; lanes and latches stay driven until idle
			ST_WAIT: begin
				if (st_r.count == 28'h0) begin
					st_nxt.state = ST_IDLE;
				end
			end
			default: st_nxt.state = ST_POWER;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.state <= ST_POWER;
			st_r.pins.chipEnable_n <= 1'b1;
			st_r.pins.writeStrobe_n <= 1'b1;
			st_r.pins.readStrobe_n <= 1'b1;
			st_r.ctrl <= nabi_pkg::CTRL_RESET;
			st_r.count <= 28'(POWER_WAIT);
			st_r.busy <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign ioOut = st_r.pins.ioOut;
	assign ioOe = st_r.pins.ioOe;
	assign chipEnable_n = st_r.pins.chipEnable_n;
	assign cmdLatch = st_r.pins.cmdLatch;
	assign addrLatch = st_r.pins.addrLatch;
	assign writeStrobe_n = st_r.pins.writeStrobe_n;
	assign readStrobe_n = st_r.pins.readStrobe_n;
	assign writeProtect_n = st_r.pins.writeProtect_n;
endmodule
`default_nettype wire

// ### rtl/nabi_pkg.sv
// Package with constants and carrier types for the flash bus host controller
package nabi_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 250;
	localparam int POWER_WAIT_US = 100;
	localparam int POWER_WAIT_CYC = POWER_WAIT_US * CLK_MHZ;
	localparam int RESET_BUSY_MS = 1;
	localparam int RESET_BUSY_CYC = RESET_BUSY_MS * 1000 * CLK_MHZ;
	localparam int PROTECT_SETTLE_NS = 100;
	localparam int PROTECT_SETTLE_CYC = (PROTECT_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_CYCLE_TIME_NS = 32;
	localparam int LATE_SAMPLE_NS = 30;
	localparam int STROBE_HALF_NS = 16;
	localparam int STROBE_HALF_CYC = (STROBE_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] STROBE_HALF = 4'(STROBE_HALF_CYC);
	// Command codes
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_ADDR_STATUS = 8'h78;
	localparam logic [7:0] CMD_READ_MODE = 8'h00;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_RDATA = 8'h0C;
	// Control register fields
	localparam int CTRL_KIND_LSB = 16;
	localparam int CTRL_GO_BIT = 20;
	localparam int CTRL_PROT_BIT = 21;
	localparam int CTRL_CE_BIT = 22;
	localparam int CTRL_WIDE_BIT = 23;
	localparam logic [31:0] CTRL_RESET = 32'h0040_0000;
	// Cycle kinds
	typedef enum logic [2:0] {
		KIND_CMD = 3'h0,
		KIND_ADDR = 3'h1,
		KIND_WRITE = 3'h2,
		KIND_READ = 3'h3,
		KIND_PROT = 3'h4
	} nabi_kind_e;
	// Pin group toward the flash
	typedef struct packed {
		logic chipEnable_n;
		logic cmdLatch;
		logic addrLatch;
		logic writeStrobe_n;
		logic readStrobe_n;
		logic writeProtect_n;
		logic [15:0] ioOut;
		logic ioOe;
	} nabi_pins_s;
	// APB request group
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} nabi_apb_s;
endpackage

// ### rtl/nabi_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module nabi_sync #(
	parameter int W = 17
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output var logic [W-1:0] q
);
	logic [W-1:0] stage1;
	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			q <= '0;
		end else begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule
`default_nettype wire

// ### tb/nabi_flash_model.sv
// Behavioural flash target on the strobe bus
`timescale 1ns/1ns
`default_nettype none
module nabi_flash_model #(
	parameter int BUSY_NS = 2000
) (
	input wire logic chipEnable_n,
	input wire logic cmdLatch,
	input wire logic addrLatch,
	input wire logic writeStrobe_n,
	input wire logic readStrobe_n,
	input wire logic writeProtect_n,
	input wire logic [15:0] ioOut,
	output logic [15:0] ioIn,
	output logic readyBusy_n
);
	logic [15:0] cache [0:7];
	logic [15:0] q = 16'h0000;
	logic [7:0] c;
	logic [7:0] firstCmd = 8'h00;
	logic [2:0] ptr = 3'h0;
	logic busy = 1'b0, drv = 1'b0, statMode = 1'b0, anyCmd = 1'b0;
	logic enhMode = 1'b0;
	int nAddr = 0;
	// Open drain with pull-up, low while busy
	assign readyBusy_n = busy ? 1'b0 : 1'b1;
	// Released lanes show the inverse of the last word
	assign ioIn = drv ? q : ~q;
	// Live from power-on; latch on write strobe rise
	always @(posedge writeStrobe_n) begin
		c = ioOut[7:0];
		if (!chipEnable_n && readStrobe_n && cmdLatch && !addrLatch) begin
			if (!anyCmd) firstCmd = c;
			anyCmd = 1'b1;
			if (!busy || c inside {8'h70, 8'h78, 8'hFF}) begin
				statMode = c inside {8'h70, 8'h78};
				enhMode = (c == 8'h78);
				ptr = 3'h0;
				nAddr = 0;
				if (c == 8'hFF) begin
					busy = 1'b1;
					busy <= #(BUSY_NS) 1'b0;
				end
			end
		end else if (!chipEnable_n && readStrobe_n && addrLatch && !cmdLatch
			&& (!busy || enhMode)) begin
			nAddr = nAddr + 1;
		end else if (!chipEnable_n && readStrobe_n && !cmdLatch && !addrLatch && !busy) begin
			cache[ptr] = ioOut;
			ptr = ptr + 3'h1;
		end
	end
	// Word or status on read strobe fall
	always @(negedge readStrobe_n) begin
		if (!chipEnable_n && writeStrobe_n && !cmdLatch && !addrLatch) begin
			if (statMode) begin
				q = {8'h00, writeProtect_n, ~busy, 6'h00};
				drv = 1'b1;
			end else if (!busy) begin
				q = cache[ptr];
				ptr = ptr + 3'h1;
				drv = 1'b1;
			end
		end
	end
	// Short hold after the rise, release at once on deselect
	always @(posedge readStrobe_n) drv <= #12 1'b0;
	always @(posedge chipEnable_n) drv = 1'b0;
endmodule
`default_nettype wire

// ### tb/nabi_host_monitor.sv
// Checker on the host pins and APB handshake
`timescale 1ns/1ns
`default_nettype none
module nabi_host_monitor #(
	parameter int POWER_WAIT = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [15:0] ioOut,
	input wire logic ioOe,
	input wire logic chipEnable_n,
	input wire logic cmdLatch,
	input wire logic addrLatch,
	input wire logic writeStrobe_n,
	input wire logic readStrobe_n,
	input wire logic writeProtect_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	int upCnt_r;
	logic seenCmd_r;
	// Cycles since reset and first command seen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			upCnt_r <= 0;
			seenCmd_r <= 1'b0;
		end else begin
			upCnt_r <= upCnt_r + 1;
			seenCmd_r <= seenCmd_r | (cmdLatch & ~writeStrobe_n);
		end
	end
	a_cmd_upper_zero: assert property (cmdLatch && ioOe |-> ioOut[15:8] == 8'h00)
		else $error("upper lanes not zero in command");
	a_addr_upper_zero: assert property (addrLatch && ioOe |-> ioOut[15:8] == 8'h00)
		else $error("upper lanes not zero in address");
	a_write_cycle: assert property (!writeStrobe_n |-> readStrobe_n && !chipEnable_n && ioOe
		&& !(cmdLatch && addrLatch))
		else $error("bad write strobe cycle");
	a_write_hold: assert property (!writeStrobe_n |=> writeStrobe_n
		|| $stable({cmdLatch, addrLatch, ioOut}))
		else $error("latch or lanes moved under write strobe");
	a_read_cycle: assert property (!readStrobe_n |-> !ioOe && writeStrobe_n && !chipEnable_n
		&& !cmdLatch && !addrLatch)
		else $error("bad read strobe cycle");
	a_protect_idle: assert property ($changed(writeProtect_n) |-> writeStrobe_n && readStrobe_n
		&& !cmdLatch && !addrLatch)
		else $error("protect moved in a cycle");
	a_first_reset: assert property ($fell(writeStrobe_n) && cmdLatch && !seenCmd_r
		|-> ioOut[7:0] == 8'hFF)
		else $error("first command not reset");
	a_power_wait: assert property ($fell(writeStrobe_n) |-> upCnt_r >= POWER_WAIT)
		else $error("strobe before power wait");
	a_apb_answer: assert property (psel && $rose(penable) |=> pready ##1 !pready)
		else $error("apb answer timing");
endmodule
bind nabi_host nabi_host_monitor #(.POWER_WAIT(POWER_WAIT)) nabi_host_monitor_i (.clk(clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .ioOut(ioOut),
	.ioOe(ioOe), .chipEnable_n(chipEnable_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
	.writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n),
	.writeProtect_n(writeProtect_n));
`default_nettype wire

// ### tb/nabi_host_test.sv
// Testbench for the flash bus host controller
`timescale 1ns/1ns
`default_nettype none
module nabi_host_test;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ioOe, readyBusy_n, err;
	logic chipEnable_n, cmdLatch, addrLatch, writeStrobe_n, readStrobe_n, writeProtect_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] ioIn, ioOut;
	int n_errors, check_count;
	nabi_host #(.POWER_WAIT(20), .RESET_WAIT(50)) nabi_host_i (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ioIn(ioIn), .ioOut(ioOut),
		.ioOe(ioOe), .readyBusy_n(readyBusy_n), .chipEnable_n(chipEnable_n),
		.cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n),
		.readStrobe_n(readStrobe_n), .writeProtect_n(writeProtect_n));
	nabi_flash_model nabi_flash_model_i (.chipEnable_n(chipEnable_n), .cmdLatch(cmdLatch),
		.addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n),
		.writeProtect_n(writeProtect_n), .ioOut(ioOut), .ioIn(ioIn),
		.readyBusy_n(readyBusy_n));
	task results;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer, held until pready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		// Values read right after the edge are those the edge sampled
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 64);
		if (pready !== 1'b1) begin
			n_errors++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Poll a status bit until it reads the wanted level
	task waitStat(input int b, input logic v);
		int i;
		i = 0;
		do begin
			apb(1'b0, 8'h08, 32'h0);
			i++;
		end while (rd[b] !== v && i < 400);
		if (i >= 400) begin
			n_errors++;
			results();
		end
	endtask
	// Start one flash cycle, then wait for the host to go idle
	task op(input logic [2:0] k, input logic [15:0] w, input logic lvl);
		apb(1'b1, 8'h00, {8'h00, 2'b11, lvl, 1'b1, 1'b0, k, w});
		waitStat(0, 1'b0);
	endtask
	task rdChk(input string nm, input logic [15:0] exp);
		op(nabi_pkg::KIND_READ, 16'h0000, 1'b1);
		apb(1'b0, 8'h0C, 32'h0);
		chk(nm, 32'(rd[15:0]), 32'(exp));
	endtask
	task sInit;
		apb(1'b1, 8'h00, 32'h0050_0070);
		chk("go while busy", 32'(err), 32'h1);
		waitStat(1, 1'b1);
		chk("first command", 32'(nabi_flash_model_i.firstCmd), 32'h0000_00FF);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl reset", rd, nabi_pkg::CTRL_RESET);
		apb(1'b0, 8'h04, 32'h0);
		chk("unmapped", 32'(err), 32'h1);
	endtask
	task sData;
		op(nabi_pkg::KIND_CMD, 16'h0080, 1'b1);
		op(nabi_pkg::KIND_WRITE, 16'hA55A, 1'b1);
		op(nabi_pkg::KIND_WRITE, 16'h3C0F, 1'b1);
		op(nabi_pkg::KIND_CMD, 16'h5A00, 1'b1);
		rdChk("word 0", 16'hA55A);
		rdChk("word 1", 16'h3C0F);
	endtask
	task sBusy;
		op(nabi_pkg::KIND_CMD, 16'h00FF, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		chk("ready pin low", 32'(rd[2]), 32'h0);
		op(nabi_pkg::KIND_PROT, 16'h0000, 1'b1);
		chk("protect refused", 32'(rd[4]), 32'h1);
		chk("protect kept", 32'(writeProtect_n), 32'h0);
		op(nabi_pkg::KIND_WRITE, 16'h1234, 1'b1);
		op(nabi_pkg::KIND_CMD, 16'h0070, 1'b1);
		rdChk("busy status", 16'h0000);
		waitStat(2, 1'b1);
		rdChk("ready status", 16'h0040);
		op(nabi_pkg::KIND_CMD, 16'h0000, 1'b1);
		rdChk("kept word", 16'hA55A);
	endtask
	task sEnh;
		op(nabi_pkg::KIND_CMD, 16'h0078, 1'b1);
		repeat (3) op(nabi_pkg::KIND_ADDR, 16'h0000, 1'b1);
		chk("status addresses", 32'(nabi_flash_model_i.nAddr), 32'h3);
		chk("mode needed", 32'(rd[3]), 32'h1);
		op(nabi_pkg::KIND_CMD, 16'h0000, 1'b1);
		chk("mode cleared", 32'(rd[3]), 32'h0);
	endtask
	task sProt;
		op(nabi_pkg::KIND_PROT, 16'h0000, 1'b0);
		chk("protect low", 32'(writeProtect_n), 32'h0);
		chk("protect taken", 32'(rd[4]), 32'h0);
		op(nabi_pkg::KIND_PROT, 16'h0000, 1'b1);
		chk("protect high", 32'(writeProtect_n), 32'h1);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#400000;
		n_errors++;
		results();
	end
	// Reset, then the scenarios in turn
	initial begin
		{rst_n, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		sInit();
		sData();
		sBusy();
		sEnh();
		sProt();
		results();
	end
endmodule
`default_nettype wire
